// >>> design/timer2_consts.svh
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// register indexes; byte address is four times the index
`define T2_CONTROL_IDX      8'hC8
`define T2_MODE_IDX         8'hC9
`define T2_RCAP_LOW_IDX     8'hCA
`define T2_RCAP_HIGH_IDX    8'hCB
`define T2_COUNT_LOW_IDX    8'hCC
`define T2_COUNT_HIGH_IDX   8'hCD
`define T2_IRQ_ENABLE_IDX   8'hCE
`define T2_ADDR_OF(idx)     ({2'b00, (idx), 2'b00})

// control register fields
`define T2_OVERFLOW_FLAG_BIT  7
`define T2_EXT_FLAG_BIT       6
`define T2_RX_BAUD_SEL_BIT    5
`define T2_TX_BAUD_SEL_BIT    4
`define T2_EXT_ENABLE_BIT     3
`define T2_RUN_BIT            2
`define T2_CT_SELECT_BIT      1
`define T2_CAP_RELOAD_BIT     0

// mode register fields
`define T2_CLOCK_OUT_EN_BIT   1
`define T2_MODE_WRITE_MASK    8'h02

// interrupt enable register fields
`define T2_TIMER_IRQ_EN_BIT   0
`define T2_GLOBAL_IRQ_EN_BIT  1
`define T2_IRQ_EN_MASK        8'h03

// reset values
`define T2_CONTROL_RESET    8'h00
`define T2_MODE_RESET       8'h00
`define T2_BYTE_RESET       8'h00

// axi answers
`define T2_RESP_OKAY        2'b00
`define T2_RESP_SLVERR      2'b10

// peripheral clock: aclk divided by this count
`define T2_PCLK_DIVIDE      2
`define T2_PCLK_CNT_W       2
`define T2_COUNT_MAX        16'hFFFF

`endif

// >>> design/timer2_pkg.sv
package timer2_pkg;

  typedef enum logic [2:0] {
    SEL_CONTROL    = 3'b000,
    SEL_MODE       = 3'b001,
    SEL_RCAP_LOW   = 3'b010,
    SEL_RCAP_HIGH  = 3'b011,
    SEL_COUNT_LOW  = 3'b100,
    SEL_COUNT_HIGH = 3'b101,
    SEL_IRQ_ENABLE = 3'b110,
    SEL_NONE       = 3'b111
  } reg_sel_type;

  typedef enum logic [1:0] {
    MODE_CAPTURE   = 2'b00,
    MODE_RELOAD    = 2'b01,
    MODE_BAUD      = 2'b10,
    MODE_CLOCK_OUT = 2'b11
  } op_mode_type;

endpackage

// >>> design/falling_edge_detect.sv
`timescale 1ns/1ps
module falling_edge_detect (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic level_in,
  output wire logic fall_pulse
);

  logic level_q;

  // resets high, so a pin held low at reset gives one fall pulse in the first cycle after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b1;
    end else begin
      level_q <= level_in;
    end
  end

  assign fall_pulse = level_q & ~level_in;

endmodule

// >>> design/periph_clock_divider.sv
`timescale 1ns/1ps
`include "timer2_consts.svh"
module periph_clock_divider (
  input  wire logic aclk,
  input  wire logic aresetn,
  output wire logic tick
);

  logic [`T2_PCLK_CNT_W-1:0] div_q;

  assign tick = (div_q == `T2_PCLK_CNT_W'(`T2_PCLK_DIVIDE - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + `T2_PCLK_CNT_W'(1);
    end
  end

endmodule

// >>> design/timer2_capture_reload_counter.sv
// Function
// - sixteen-bit up counter in two byte registers
// - select bit picks peripheral clock or pin falls
// - run bit gates counting, halt keeps count
// - overflow sets sticky flag bit 7
// - no overflow flag in baud or clock-out
// - enabled trigger fall sets flag bit 6
// - interrupt when flag set and both enabled
// - receive baud source select bit 5
// - transmit baud source select bit 4
// - trigger enable bit gates trigger edges
// - select bit picks reload or capture
// - baud selects force auto-reload mode
// - clock-out enable drives count pin only with internal clock (select bit 1 low)
// - low reload byte captures or supplies reload
// - control, mode, reload bytes reset zero
// - capture copies both bytes, counting continues
// - rollover outside capture mode reloads both counter bytes
// - baud mode rollover is uart strobe
// - clock-out toggles pin on each reload
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "timer2_consts.svh"
module timer2_capture_reload_counter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        count_pin_in,
  output logic             count_pin_out,
  output logic             count_pin_oe_n,
  input  wire logic        trigger_pin_in,
  input  wire logic        timer1_overflow,
  output logic             rx_baud_strobe,
  output logic             tx_baud_strobe,
  output logic             overflow_strobe,
  output logic             timer_irq
);

  function automatic timer2_pkg::reg_sel_type decode(input logic [11:0] addr);
    case (addr)
      `T2_ADDR_OF(`T2_CONTROL_IDX):    decode = timer2_pkg::SEL_CONTROL;
      `T2_ADDR_OF(`T2_MODE_IDX):       decode = timer2_pkg::SEL_MODE;
      `T2_ADDR_OF(`T2_RCAP_LOW_IDX):   decode = timer2_pkg::SEL_RCAP_LOW;
      `T2_ADDR_OF(`T2_RCAP_HIGH_IDX):  decode = timer2_pkg::SEL_RCAP_HIGH;
      `T2_ADDR_OF(`T2_COUNT_LOW_IDX):  decode = timer2_pkg::SEL_COUNT_LOW;
      `T2_ADDR_OF(`T2_COUNT_HIGH_IDX): decode = timer2_pkg::SEL_COUNT_HIGH;
      `T2_ADDR_OF(`T2_IRQ_ENABLE_IDX): decode = timer2_pkg::SEL_IRQ_ENABLE;
      default:                         decode = timer2_pkg::SEL_NONE;
    endcase
  endfunction

  logic [7:0]  control_q;
  logic [7:0]  mode_q;
  logic [7:0]  irq_enable_q;
  logic [7:0]  rcap_low_q;
  logic [7:0]  rcap_high_q;
  logic [7:0]  count_low_byte_q;
  logic [7:0]  count_high_byte_q;
  logic        aw_hold_q;
  logic [11:0] aw_addr_q;
  logic        w_hold_q;
  logic [7:0]  w_data_q;
  logic        w_strb_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        count_pin_out_q;
  logic        count_pin_oe_n_q;
  logic        rx_baud_strobe_q;
  logic        tx_baud_strobe_q;
  logic        overflow_strobe_q;
  logic        timer_irq_q;
  logic                    pclk_tick;
  logic                    count_fall;
  logic                    trigger_fall;
  logic [15:0]             count_now;
  logic [15:0]             count_next;
  logic                    baud_mode;
  logic                    clock_out_mode;
  timer2_pkg::op_mode_type op_mode;
  logic                    count_tick;
  logic                    rollover;
  logic                    trigger_event;
  logic                    reload_now;
  logic                    capture_now;
  logic                    overflow_set;
  logic                    wr_go;
  logic                    wr_en;
  timer2_pkg::reg_sel_type wr_sel;
  timer2_pkg::reg_sel_type rd_sel;
  logic [7:0]              rd_byte;

  periph_clock_divider u_pclk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (pclk_tick)
  );
  falling_edge_detect u_count_edge (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .level_in   (count_pin_in),
    .fall_pulse (count_fall)
  );
  falling_edge_detect u_trigger_edge (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .level_in   (trigger_pin_in),
    .fall_pulse (trigger_fall)
  );

  assign {awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp} =
         {awready_q, wready_q, bvalid_q, bresp_q, arready_q, rvalid_q, rdata_q, rresp_q};
  assign {count_pin_out, count_pin_oe_n, rx_baud_strobe, tx_baud_strobe, overflow_strobe,
          timer_irq} = {count_pin_out_q, count_pin_oe_n_q, rx_baud_strobe_q,
                        tx_baud_strobe_q, overflow_strobe_q, timer_irq_q};

  // operating mode
  assign count_now  = {count_high_byte_q, count_low_byte_q};
  assign count_next = count_now + 16'h0001;
  assign baud_mode  = control_q[`T2_RX_BAUD_SEL_BIT] | control_q[`T2_TX_BAUD_SEL_BIT];
  // clock-out only with the internal clock; a high select bit 1 turns it off
  assign clock_out_mode = mode_q[`T2_CLOCK_OUT_EN_BIT] & ~control_q[`T2_CT_SELECT_BIT];

  always_comb begin
    if (baud_mode) begin
      op_mode = timer2_pkg::MODE_BAUD;
    end else if (clock_out_mode) begin
      op_mode = timer2_pkg::MODE_CLOCK_OUT;
    end else if (control_q[`T2_CAP_RELOAD_BIT]) begin
      op_mode = timer2_pkg::MODE_CAPTURE;
    end else begin
      op_mode = timer2_pkg::MODE_RELOAD;
    end
  end

  // counting events
  assign count_tick = control_q[`T2_RUN_BIT] &
                      (control_q[`T2_CT_SELECT_BIT] ? count_fall : pclk_tick);
  assign rollover      = count_tick & (count_now == `T2_COUNT_MAX);
  assign trigger_event = control_q[`T2_EXT_ENABLE_BIT] & trigger_fall;

  // capture mode just wraps to zero; every other mode reloads
  assign reload_now  = (rollover & (op_mode != timer2_pkg::MODE_CAPTURE)) |
                       (trigger_event & (op_mode == timer2_pkg::MODE_RELOAD));
  assign capture_now = trigger_event & (op_mode == timer2_pkg::MODE_CAPTURE);
  assign overflow_set = rollover & ((op_mode == timer2_pkg::MODE_CAPTURE) |
                                    (op_mode == timer2_pkg::MODE_RELOAD));

  // register write port
  assign wr_go  = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_sel = decode(aw_addr_q);
  assign wr_en  = wr_go & w_strb_q;
  assign rd_sel = decode(araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 12'h000;
      awready_q <= 1'b0;
    end else if (awvalid && awready_q) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= awaddr;
      awready_q <= 1'b0;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end else if (!aw_hold_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      wready_q <= 1'b0;
    end else if (wvalid && wready_q) begin
      w_hold_q <= 1'b1;
      w_data_q <= wdata[7:0];
      w_strb_q <= wstrb[0];
      wready_q <= 1'b0;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end else if (!w_hold_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `T2_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_sel == timer2_pkg::SEL_NONE) ? `T2_RESP_SLVERR : `T2_RESP_OKAY;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // register read port
  always_comb begin
    case (rd_sel)
      timer2_pkg::SEL_CONTROL:    rd_byte = control_q;
      timer2_pkg::SEL_MODE:       rd_byte = mode_q & `T2_MODE_WRITE_MASK;
      timer2_pkg::SEL_RCAP_LOW:   rd_byte = rcap_low_q;
      timer2_pkg::SEL_RCAP_HIGH:  rd_byte = rcap_high_q;
      timer2_pkg::SEL_COUNT_LOW:  rd_byte = count_low_byte_q;
      timer2_pkg::SEL_COUNT_HIGH: rd_byte = count_high_byte_q;
      timer2_pkg::SEL_IRQ_ENABLE: rd_byte = irq_enable_q;
      default:                    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `T2_RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h000000, rd_byte};
      rresp_q   <= (rd_sel == timer2_pkg::SEL_NONE) ? `T2_RESP_SLVERR : `T2_RESP_OKAY;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // control register; a software write overrides a same-cycle flag set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= `T2_CONTROL_RESET;
    end else if (wr_en && wr_sel == timer2_pkg::SEL_CONTROL) begin
      control_q <= w_data_q;
    end else begin
      if (overflow_set) begin
        control_q[`T2_OVERFLOW_FLAG_BIT] <= 1'b1;
      end
      if (trigger_event) begin
        control_q[`T2_EXT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `T2_MODE_RESET;
    end else if (wr_en && wr_sel == timer2_pkg::SEL_MODE) begin
      mode_q <= w_data_q & `T2_MODE_WRITE_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_q <= `T2_BYTE_RESET;
    end else if (wr_en && wr_sel == timer2_pkg::SEL_IRQ_ENABLE) begin
      irq_enable_q <= w_data_q & `T2_IRQ_EN_MASK;
    end
  end

  // reload/capture pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcap_low_q <= `T2_BYTE_RESET;
    end else if (wr_en && wr_sel == timer2_pkg::SEL_RCAP_LOW) begin
      rcap_low_q <= w_data_q;
    end else if (capture_now) begin
      rcap_low_q <= count_now[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcap_high_q <= `T2_BYTE_RESET;
    end else if (wr_en && wr_sel == timer2_pkg::SEL_RCAP_HIGH) begin
      rcap_high_q <= w_data_q;
    end else if (capture_now) begin
      rcap_high_q <= count_now[15:8];
    end
  end

  // counter bytes; writing while running is allowed but racy for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_low_byte_q <= `T2_BYTE_RESET;
    end else if (wr_en && wr_sel == timer2_pkg::SEL_COUNT_LOW) begin
      count_low_byte_q <= w_data_q;
    end else if (reload_now) begin
      count_low_byte_q <= rcap_low_q;
    end else if (count_tick) begin
      count_low_byte_q <= count_next[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_high_byte_q <= `T2_BYTE_RESET;
    end else if (wr_en && wr_sel == timer2_pkg::SEL_COUNT_HIGH) begin
      count_high_byte_q <= w_data_q;
    end else if (reload_now) begin
      count_high_byte_q <= rcap_high_q;
    end else if (count_tick) begin
      count_high_byte_q <= count_next[15:8];
    end
  end

  // side outputs; a selected baud source passes each rollover as the uart strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_baud_strobe_q  <= 1'b0;
      tx_baud_strobe_q  <= 1'b0;
      overflow_strobe_q <= 1'b0;
      timer_irq_q       <= 1'b0;
    end else begin
      rx_baud_strobe_q  <= control_q[`T2_RX_BAUD_SEL_BIT] ? rollover : timer1_overflow;
      tx_baud_strobe_q  <= control_q[`T2_TX_BAUD_SEL_BIT] ? rollover : timer1_overflow;
      overflow_strobe_q <= rollover;
      timer_irq_q       <= (control_q[`T2_OVERFLOW_FLAG_BIT] | control_q[`T2_EXT_FLAG_BIT]) &
                           irq_enable_q[`T2_TIMER_IRQ_EN_BIT] &
                           irq_enable_q[`T2_GLOBAL_IRQ_EN_BIT];
    end
  end

  // clock-out: toggling once per reload gives an even duty cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_pin_out_q  <= 1'b0;
      count_pin_oe_n_q <= 1'b1;
    end else begin
      count_pin_oe_n_q <= ~clock_out_mode;
      if (!clock_out_mode) begin
        count_pin_out_q <= 1'b0;
      end else if (rollover) begin
        count_pin_out_q <= ~count_pin_out_q;
      end
    end
  end

endmodule

// >>> verification/timer2_checker.sv
`timescale 1ns/1ps
`include "timer2_consts.svh"
module timer2_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        count_pin_out,
  input wire logic        count_pin_oe_n,
  input wire logic        timer1_overflow,
  input wire logic        rx_baud_strobe,
  input wire logic        tx_baud_strobe,
  input wire logic        overflow_strobe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_R_ERR_ZERO: assert property (rvalid && rresp == `T2_RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read carries data");
  AST_OVF_PULSE: assert property (overflow_strobe |=> !overflow_strobe)
    else $error("rollover strobe too long");
  AST_PIN_IDLE: assert property (count_pin_oe_n |-> !count_pin_out)
    else $error("pin value while not driven");
  AST_TOGGLE_CAUSE: assert property ($changed(count_pin_out) && !count_pin_oe_n
    && !$past(count_pin_oe_n) |-> overflow_strobe) else $error("clock-out toggle without rollover");
  AST_TX_SOURCE: assert property (tx_baud_strobe |->
    $past(timer1_overflow) || overflow_strobe || $past(overflow_strobe))
    else $error("tx strobe uncaused");
  AST_RX_SOURCE: assert property (rx_baud_strobe |->
    $past(timer1_overflow) || overflow_strobe || $past(overflow_strobe))
    else $error("rx strobe uncaused");

  cover property (overflow_strobe);
  cover property (tx_baud_strobe && rx_baud_strobe);
  cover property (!count_pin_oe_n && $rose(count_pin_out));
endmodule

// >>> verification/timer2_pin_partner.sv
`timescale 1ns/1ps
module timer2_pin_partner (
  input  wire logic aclk,
  input  wire logic count_pin_out,
  input  wire logic count_pin_oe_n,
  output wire logic count_pin_in,
  output logic      trigger_pin_in,
  output logic      timer1_overflow
);
  logic ext_lvl;
  // pull-up holds the pin high whenever nobody drives it
  assign count_pin_in = count_pin_oe_n ? ext_lvl : count_pin_out;
  initial begin
    ext_lvl = 1'b1;
    trigger_pin_in = 1'b1;
    timer1_overflow = 1'b0;
  end
  task automatic trig_fall();
    @(posedge aclk) trigger_pin_in <= 1'b0;
    repeat (3) @(posedge aclk);
    trigger_pin_in <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic count_falls(input int n);
    repeat (n) begin
      @(posedge aclk) ext_lvl <= 1'b0;
      repeat (2) @(posedge aclk);
      ext_lvl <= 1'b1;
      @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
  endtask
  task automatic t1_pulse();
    @(posedge aclk) timer1_overflow <= 1'b1;
    @(posedge aclk) timer1_overflow <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
endmodule

// >>> verification/timer2_capture_reload_counter_tb.sv
`timescale 1ns/1ps
`include "timer2_consts.svh"
module timer2_capture_reload_counter_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_resp;
  logic        count_pin_in, count_pin_out, count_pin_oe_n, trigger_pin_in, timer1_overflow;
  logic        rx_baud_strobe, tx_baud_strobe, overflow_strobe, timer_irq, tgl_prev;
  logic [7:0]  rd_byte;
  int          n_mismatch = 0, check_count = 0, n_tx = 0, n_rx = 0, n_tgl = 0, b0, b1;
  localparam logic [11:0] A_CTL = `T2_ADDR_OF(`T2_CONTROL_IDX);
  localparam logic [11:0] A_MOD = `T2_ADDR_OF(`T2_MODE_IDX);
  localparam logic [11:0] A_RCL = `T2_ADDR_OF(`T2_RCAP_LOW_IDX);
  localparam logic [11:0] A_RCH = `T2_ADDR_OF(`T2_RCAP_HIGH_IDX);
  localparam logic [11:0] A_CL  = `T2_ADDR_OF(`T2_COUNT_LOW_IDX);
  localparam logic [11:0] A_CH  = `T2_ADDR_OF(`T2_COUNT_HIGH_IDX);
  localparam logic [11:0] A_IRQ = `T2_ADDR_OF(`T2_IRQ_ENABLE_IDX);

  timer2_capture_reload_counter i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .count_pin_in, .count_pin_out, .count_pin_oe_n, .trigger_pin_in,
    .timer1_overflow, .rx_baud_strobe, .tx_baud_strobe, .overflow_strobe, .timer_irq);
  timer2_pin_partner i_pins (.aclk, .count_pin_out, .count_pin_oe_n, .count_pin_in,
    .trigger_pin_in, .timer1_overflow);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // running tallies; scenarios work on differences so nothing races a reset
  always @(posedge aclk) begin
    if (tx_baud_strobe === 1'b1) n_tx++;
    if (rx_baud_strobe === 1'b1) n_rx++;
    if (count_pin_out !== tgl_prev) n_tgl++;
    tgl_prev = count_pin_out;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic chk_ge(input int got, input int lo, input string w);
    chk({7'h0, got >= lo}, 8'h01, w);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_byte = rdata[7:0];
    last_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e, input string w);
    rd(a);
    chk(rd_byte, e, w);
  endtask

  initial begin
    idle(20000);
    n_mismatch++;
    test_done();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    idle(8);
    aresetn <= 1'b1;
    idle(2);
    rc(A_CTL, 8'h00, "control reset");
    rc(A_MOD, 8'h00, "mode reset");
    rc(A_RCL, 8'h00, "reload low reset");
    rd(12'h000);
    chk({6'h0, last_resp}, {6'h0, `T2_RESP_SLVERR}, "unmapped read");
    wr(12'h004, 8'h55);
    chk({6'h0, last_resp}, {6'h0, `T2_RESP_SLVERR}, "unmapped write");
    wr(A_MOD, 8'hFF);
    rc(A_MOD, 8'h02, "mode reserved bits");
    wr(A_MOD, 8'h00);
    $display("test registers finished");

    wr(A_CL, 8'hFF);
    wr(A_CH, 8'hFF);
    wr(A_CTL, 8'h05);
    idle(20);
    rc(A_CTL, 8'h85, "overflow flag in capture");
    wr(A_IRQ, 8'h03);
    idle(3);
    chk({7'h0, timer_irq}, 8'h01, "irq raised");
    wr(A_IRQ, 8'h01);
    idle(3);
    chk({7'h0, timer_irq}, 8'h00, "irq global off");
    wr(A_IRQ, 8'h03);
    rc(A_CTL, 8'h85, "flag sticky");
    wr(A_CTL, 8'h01);
    rc(A_CTL, 8'h01, "flag cleared by write");
    idle(3);
    chk({7'h0, timer_irq}, 8'h00, "irq dropped");
    $display("test overflow finished");

    wr(A_RCL, 8'h78);
    wr(A_RCH, 8'h56);
    wr(A_CL, 8'hFF);
    wr(A_CH, 8'hFF);
    wr(A_CTL, 8'h04);
    idle(6);
    rc(A_CTL, 8'h84, "reload flag");
    wr(A_CTL, 8'h00);
    rc(A_CH, 8'h56, "reload into high byte");
    $display("test reload finished");

    wr(A_RCL, 8'hFE);
    wr(A_RCH, 8'hFF);
    // start next to the top so rollovers come every few cycles, not after a long climb
    wr(A_CL, 8'hFE);
    wr(A_CH, 8'hFF);
    b0 = n_tx;
    b1 = n_rx;
    wr(A_CTL, 8'h35);
    idle(40);
    rc(A_CTL, 8'h35, "no flag in baud mode");
    chk_ge(n_tx - b0, 8, "tx strobes from rollover");
    chk_ge(n_rx - b1, 8, "rx strobes from rollover");
    wr(A_CTL, 8'h00);
    rc(A_CH, 8'hFF, "baud forces auto-reload");
    b0 = n_tx;
    b1 = n_rx;
    repeat (3) i_pins.t1_pulse();
    chk(8'(n_tx - b0), 8'h03, "tx from timer one");
    chk(8'(n_rx - b1), 8'h03, "rx from timer one");
    $display("test baud finished");

    wr(A_MOD, 8'h02);
    b0 = n_tgl;
    wr(A_CTL, 8'h04);
    idle(40);
    chk({7'h0, count_pin_oe_n}, 8'h00, "pin driven");
    chk_ge(n_tgl - b0, 6, "clock-out toggles");
    rc(A_CTL, 8'h04, "no flag in clock-out");
    wr(A_CTL, 8'h06);
    idle(3);
    chk({7'h0, count_pin_oe_n}, 8'h01, "select one releases pin");
    wr(A_CTL, 8'h00);
    wr(A_MOD, 8'h00);
    $display("test clock-out finished");

    wr(A_CL, 8'h34);
    wr(A_CH, 8'h12);
    wr(A_CTL, 8'h01);
    i_pins.trig_fall();
    rc(A_CTL, 8'h01, "edge ignored flag");
    rc(A_RCL, 8'hFE, "edge ignored capture");
    wr(A_CTL, 8'h09);
    i_pins.trig_fall();
    rc(A_CTL, 8'h49, "external flag");
    rc(A_RCL, 8'h34, "capture low");
    rc(A_RCH, 8'h12, "capture high");
    wr(A_CTL, 8'h08);
    wr(A_CL, 8'h00);
    wr(A_CH, 8'h00);
    i_pins.trig_fall();
    rc(A_CL, 8'h34, "trigger reload low");
    rc(A_CH, 8'h12, "trigger reload high");
    rc(A_CTL, 8'h48, "external flag again");
    $display("test trigger finished");

    wr(A_CTL, 8'h00);
    wr(A_CL, 8'hFE);
    wr(A_CH, 8'h00);
    wr(A_CTL, 8'h06);
    i_pins.count_falls(5);
    wr(A_CTL, 8'h02);
    i_pins.count_falls(3);
    rc(A_CL, 8'h03, "pin falls counted, halt holds");
    rc(A_CH, 8'h01, "carry into high byte");
    $display("test counter finished");
    test_done();
  end
endmodule

bind timer2_capture_reload_counter timer2_checker i_chk (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .rresp, .count_pin_out, .count_pin_oe_n, .timer1_overflow, .rx_baud_strobe, .tx_baud_strobe,
  .overflow_strobe);
